/* lin_wake_pkg.sv */
/*
  Constants and mode types for the transceiver wake-up and mode control.
  Assumes a single 10 MHz clock, mclk, and a synchronous active-high reset.
*/
// Behaviour
// [RULE1] Bus below prewake threshold: receiver, termination on.
// [RULE2] Remote wake: fall, dominant filter time, rise.
// [RULE3] Remote wake: fail-safe, inhibit on, termination on.
// [RULE4] Pending remote wake drives receive output low.
// [RULE5] Local wake: wake falls, low for filter time.
// [RULE6] Local wake: receive low, strong transmit pull-down.
// [RULE7] Low enable sleeps even with wake held low.
// [RULE8] New local wake needs wake high over 6us.
// [RULE9] Fail-safe transmit pin: weak remote, strong local.
// [RULE10] Host pull-up reads high remote, low local.
// [RULE11] Enable high clears both wake indications immediately.
// [RULE12] Open enable reads low, forcing sleep.
// [RULE13] Open transmit input reads static low.
// [RULE14] Overtemperature disables driver until hysteresis passes.
// [RULE15] Enable high in fail-safe enters normal mode.
// [RULE16] Enable falling with transmit high enters sleep.
// [RULE17] Power-up above undervoltage enters fail-safe, inhibit on.
// [RULE18] Released before filter time: wake abandoned.
// [RULE19] Filter timers internal, durations configurable constants.
package lin_wake_pkg;

  localparam int unsigned CLK_HZ         = 10_000_000;
  localparam int unsigned BUS_FILTER_NS  = 90_000;
  localparam int unsigned WAKE_FILTER_NS = 35_000;
  localparam int unsigned WAKE_HIGH_NS   = 6_000;
  localparam int unsigned NS_PER_CYCLE   = 1_000_000_000 / CLK_HZ;
  localparam int unsigned BUS_FILTER_CYC  = (BUS_FILTER_NS + NS_PER_CYCLE - 1) / NS_PER_CYCLE;
  localparam int unsigned WAKE_FILTER_CYC = (WAKE_FILTER_NS + NS_PER_CYCLE - 1) / NS_PER_CYCLE;
  localparam int unsigned WAKE_HIGH_CYC   = WAKE_HIGH_NS / NS_PER_CYCLE + 1;
  localparam int unsigned CNT_W           = 10;

  typedef enum logic [1:0] {
    SRC_NONE,
    SRC_REMOTE,
    SRC_LOCAL
  } wake_src_type;

  typedef enum {
    MODE_UNPOWERED,
    MODE_SLEEP,
    MODE_FAILSAFE,
    MODE_NORMAL
  } mode_type;

endpackage

/* lin_wake_if.sv */
/*
  Carries the qualified wake pulses from the filter to the mode control.
  Assumes both ends run on mclk.
*/
interface lin_wake_if;
  logic remote_wake;
  logic local_wake;
  logic asleep;
  modport filter (output remote_wake, output local_wake, input asleep);
  modport control (input remote_wake, input local_wake, output asleep);
endinterface

/* lin_wake_filter.sv */
/*
  Filters the bus and wake-pin levels into one-cycle wake pulses.
  Assumes inputs are already synchronised to mclk.
*/
module lin_wake_filter
(
  // Clock and reset.
  input  wire logic   mclk,
  input  wire logic   sys_rst,
  // Synchronised levels.
  input  wire logic   bus_dominant,
  input  wire logic   wake_low,
  // Pulses to the mode control.
  lin_wake_if.filter  wk
);

  logic [lin_wake_pkg::CNT_W-1:0] bus_cnt;
  logic [lin_wake_pkg::CNT_W-1:0] next_bus_cnt;
  logic                           bus_ok;
  logic                           next_bus_ok;
  logic [lin_wake_pkg::CNT_W-1:0] wake_cnt;
  logic [lin_wake_pkg::CNT_W-1:0] next_wake_cnt;
  logic [lin_wake_pkg::CNT_W-1:0] high_cnt;
  logic [lin_wake_pkg::CNT_W-1:0] next_high_cnt;
  logic                           armed;
  logic                           next_armed;
  logic                           remote;
  logic                           next_remote;
  logic                           local_p;
  logic                           next_local_p;

  // Filter times come from the clock, standing in for the internal oscillator.
  always_comb
  begin
    next_bus_cnt  = '0;
    next_bus_ok   = bus_ok;
    next_remote   = 1'b0;
    next_wake_cnt = '0;
    next_high_cnt = high_cnt;
    next_armed    = armed;
    next_local_p  = 1'b0;
    if (!wk.asleep)
    begin
      next_bus_ok = 1'b0;
    end
    else if (bus_dominant)
    begin
      if (bus_cnt < lin_wake_pkg::CNT_W'(lin_wake_pkg::BUS_FILTER_CYC))
      begin
        next_bus_cnt = bus_cnt + 1'b1; // [RULE19]
      end
      else
      begin
        next_bus_cnt = bus_cnt;
        next_bus_ok  = 1'b1; // [RULE2]
      end
    end
    else
    begin
      next_remote = bus_ok; // [RULE2]
      next_bus_ok = 1'b0; // [RULE18]
    end
    if (!wake_low)
    begin
      if (high_cnt < lin_wake_pkg::CNT_W'(lin_wake_pkg::WAKE_HIGH_CYC))
      begin
        next_high_cnt = high_cnt + 1'b1;
      end
      else
      begin
        next_armed = 1'b1; // [RULE8]
      end
    end
    else
    begin
      next_high_cnt = '0;
      if (armed && wk.asleep)
      begin
        if (wake_cnt < lin_wake_pkg::CNT_W'(lin_wake_pkg::WAKE_FILTER_CYC - 1))
        begin
          next_wake_cnt = wake_cnt + 1'b1;
        end
        else
        begin
          next_local_p = 1'b1; // [RULE5]
          next_armed   = 1'b0; // [RULE8]
        end
      end
      // A fall seen while awake is spent, so a sleep with the pin held low cannot wake locally.
      if (!wk.asleep)
      begin
        next_armed = 1'b0; // [RULE7]
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      bus_cnt  <= '0;
      bus_ok   <= 1'b0;
      remote   <= 1'b0;
      wake_cnt <= '0;
      high_cnt <= '0;
      armed    <= 1'b0;
      local_p  <= 1'b0;
    end
    else
    begin
      bus_cnt  <= next_bus_cnt;
      bus_ok   <= next_bus_ok;
      remote   <= next_remote;
      wake_cnt <= next_wake_cnt;
      high_cnt <= next_high_cnt;
      armed    <= next_armed;
      local_p  <= next_local_p;
    end
  end

  assign wk.remote_wake = remote;
  assign wk.local_wake  = local_p;

  a_local_needs_armed: assert property (@(posedge mclk) disable iff (sys_rst)
    local_p |-> $past(wake_low, 1) && !armed) // [RULE8]
    else $error("local wake without rearm");

  a_remote_after_low: assert property (@(posedge mclk) disable iff (sys_rst)
    remote |-> $past(!bus_dominant, 1) && $past(bus_ok, 1)) // [RULE2]
    else $error("remote wake without qualified dominant");

endmodule

/* lin_wake_ctrl.sv */
/*
  Mode control of the transceiver: sleep, fail-safe and normal modes, wake
  indication on the receive and transmit pins, inhibit and driver enable.
  Assumes pin levels arrive asynchronously and a supply-good level from an
  undervoltage comparator; pin pull-ups and pull-downs are modelled by the
  open-drain enables.
*/
module lin_wake_ctrl
(
  // Clock and reset.
  input  wire logic  mclk,
  input  wire logic  sys_rst,
  // Analog comparator levels.
  input  wire logic  supply_ok,
  input  wire logic  prewake_threshold,
  input  wire logic  dominant_level,
  input  wire logic  overtemp,
  input  wire logic  overtemp_clear,
  // Host pins.
  input  wire logic  en_pin,
  input  wire logic  en_open,
  input  wire logic  txd_in,
  input  wire logic  txd_open,
  input  wire logic  wake_pin,
  output logic       rxd_out,
  output logic       rxd_oe,
  output logic       txd_out,
  output logic       txd_oe,
  output logic       txd_strong,
  // Bus and supply side.
  output logic       bus_drive_low,
  output logic       receiver_on,
  output logic       termination_on,
  output logic       regulator_inhibit_out
);

  logic [1:0]                 en_s;
  logic [1:0]                 txd_s;
  logic [1:0]                 wake_s;
  logic [1:0]                 dom_s;
  logic [1:0]                 pre_s;
  logic [1:0]                 sup_s;
  logic [1:0]                 ot_s;
  logic [1:0]                 otc_s;
  logic                       txd_q;
  lin_wake_pkg::mode_type     mode;
  lin_wake_pkg::mode_type     next_mode;
  lin_wake_pkg::wake_src_type src;
  lin_wake_pkg::wake_src_type next_src;
  logic                       en_prev;
  logic                       drv_off;
  logic                       next_drv_off;
  logic                       en_eff;
  logic                       txd_eff;
  logic                       rx_low;
  logic                       tx_low;
  logic                       next_rx_low;
  logic                       next_tx_low;

  lin_wake_if wk ();

  // Every pin passes two flops before any logic looks at it.
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      en_s   <= 2'h0;
      txd_s  <= 2'h0;
      wake_s <= 2'h3;
      dom_s  <= 2'h0;
      pre_s  <= 2'h0;
      sup_s  <= 2'h0;
      ot_s   <= 2'h0;
      otc_s  <= 2'h0;
    end
    else
    begin
      en_s   <= {en_s[0], en_pin & ~en_open}; // [RULE12]
      txd_s  <= {txd_s[0], txd_in & ~txd_open}; // [RULE13]
      wake_s <= {wake_s[0], wake_pin};
      dom_s  <= {dom_s[0], dominant_level};
      pre_s  <= {pre_s[0], prewake_threshold};
      sup_s  <= {sup_s[0], supply_ok};
      ot_s   <= {ot_s[0], overtemp};
      otc_s  <= {otc_s[0], overtemp_clear};
    end
  end

  assign en_eff  = en_s[1];
  assign txd_eff = txd_s[1];

  lin_wake_filter u_filter
  (
    .mclk         (mclk),
    .sys_rst      (sys_rst),
    .bus_dominant (dom_s[1]),
    .wake_low     (~wake_s[1]),
    .wk           (wk.filter)
  );

  assign wk.asleep = (mode == lin_wake_pkg::MODE_SLEEP);

  always_comb
  begin
    next_mode    = mode;
    next_src     = src;
    next_rx_low  = rx_low;
    next_tx_low  = tx_low;
    next_drv_off = drv_off;
    if (ot_s[1])
    begin
      next_drv_off = 1'b1; // [RULE14]
    end
    else if (otc_s[1])
    begin
      next_drv_off = 1'b0; // [RULE14]
    end
    unique case (mode)
      lin_wake_pkg::MODE_UNPOWERED:
      begin
        if (sup_s[1])
        begin
          next_mode = lin_wake_pkg::MODE_FAILSAFE; // [RULE17]
        end
      end
      lin_wake_pkg::MODE_SLEEP:
      begin
        // A sleep entered with wake held low gets no local wake until wake rearms.
        if (wk.local_wake)
        begin
          next_mode   = lin_wake_pkg::MODE_FAILSAFE; // [RULE5]
          next_src    = lin_wake_pkg::SRC_LOCAL;
          next_rx_low = 1'b1; // [RULE6]
          next_tx_low = 1'b1; // [RULE6]
        end
        else if (wk.remote_wake)
        begin
          next_mode   = lin_wake_pkg::MODE_FAILSAFE; // [RULE3]
          next_src    = lin_wake_pkg::SRC_REMOTE;
          next_rx_low = 1'b1; // [RULE4]
        end
      end
      lin_wake_pkg::MODE_FAILSAFE:
      begin
        if (en_eff)
        begin
          next_mode   = lin_wake_pkg::MODE_NORMAL; // [RULE15]
          next_src    = lin_wake_pkg::SRC_NONE; // [RULE11]
          next_rx_low = 1'b0; // [RULE11]
          next_tx_low = 1'b0; // [RULE11]
        end
      end
      lin_wake_pkg::MODE_NORMAL:
      begin
        if (en_prev && !en_eff && txd_eff)
        begin
          next_mode = lin_wake_pkg::MODE_SLEEP; // [RULE16]
        end
        else if (en_prev && !en_eff)
        begin
          next_mode = lin_wake_pkg::MODE_SLEEP; // [RULE7]
        end
      end
    endcase
    if (!sup_s[1])
    begin
      next_mode   = lin_wake_pkg::MODE_UNPOWERED;
      next_src    = lin_wake_pkg::SRC_NONE;
      next_rx_low = 1'b0;
      next_tx_low = 1'b0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      mode    <= lin_wake_pkg::MODE_UNPOWERED;
      src     <= lin_wake_pkg::SRC_NONE;
      rx_low  <= 1'b0;
      tx_low  <= 1'b0;
      en_prev <= 1'b0;
      drv_off <= 1'b0;
      txd_q   <= 1'b0;
    end
    else
    begin
      mode    <= next_mode;
      src     <= next_src;
      rx_low  <= next_rx_low;
      tx_low  <= next_tx_low;
      en_prev <= en_eff;
      drv_off <= next_drv_off;
      txd_q   <= txd_eff;
    end
  end

  // Open-drain receive output: low for a wake request or a dominant bus.
  always_comb
  begin
    rxd_out = 1'b0;
    rxd_oe  = 1'b0;
    if (mode == lin_wake_pkg::MODE_NORMAL)
    begin
      rxd_oe = dom_s[1];
    end
    else if (mode == lin_wake_pkg::MODE_FAILSAFE)
    begin
      rxd_oe = rx_low; // [RULE4]
    end
  end

  // Wake source on the transmit pin; the host reads it with its own pull-up.
  assign txd_out    = 1'b0;
  assign txd_oe     = (mode == lin_wake_pkg::MODE_FAILSAFE) && (src != lin_wake_pkg::SRC_NONE); // [RULE9]
  assign txd_strong = tx_low; // [RULE9]

  assign bus_drive_low  = (mode == lin_wake_pkg::MODE_NORMAL) && !txd_q && !drv_off; // [RULE14]
  assign receiver_on    = (mode != lin_wake_pkg::MODE_UNPOWERED) && (!wk.asleep || pre_s[1]); // [RULE1]
  assign termination_on = receiver_on; // [RULE1]
  assign regulator_inhibit_out = (mode == lin_wake_pkg::MODE_FAILSAFE) || (mode == lin_wake_pkg::MODE_NORMAL); // [RULE3]

  a_clear_on_enable: assert property (@(posedge mclk) disable iff (sys_rst)
    (mode == lin_wake_pkg::MODE_FAILSAFE && en_eff && sup_s[1]) |=> !rx_low && !tx_low) // [RULE11]
    else $error("wake flags not cleared by enable");

  a_wake_sets_inhibit: assert property (@(posedge mclk) disable iff (sys_rst)
    (wk.asleep && (wk.local_wake || wk.remote_wake) && sup_s[1]) |=> regulator_inhibit_out && rxd_oe) // [RULE3]
    else $error("wake did not raise inhibit and flag");

  a_local_strong: assert property (@(posedge mclk) disable iff (sys_rst)
    (wk.asleep && wk.local_wake && sup_s[1]) |=> txd_oe && txd_strong) // [RULE6]
    else $error("local wake lacks strong pull-down");

  a_sleep_no_inhibit: assert property (@(posedge mclk) disable iff (sys_rst)
    wk.asleep |-> !regulator_inhibit_out && !bus_drive_low) // [RULE16]
    else $error("inhibit on while asleep");

  a_sleep_on_fall: assert property (@(posedge mclk) disable iff (sys_rst)
    (mode == lin_wake_pkg::MODE_NORMAL && en_prev && !en_eff && txd_eff && sup_s[1]) |=> wk.asleep) // [RULE16]
    else $error("enable fall did not enter sleep");

  a_overtemp_off: assert property (@(posedge mclk) disable iff (sys_rst)
    $past(ot_s[1], 1) |-> !bus_drive_low) // [RULE14]
    else $error("driver on during overtemperature");

  a_powerup_failsafe: assert property (@(posedge mclk) disable iff (sys_rst)
    (mode == lin_wake_pkg::MODE_UNPOWERED && sup_s[1]) |=> regulator_inhibit_out) // [RULE17]
    else $error("power-up did not reach fail-safe");

endmodule

/* lin_host_model.sv */
/*
  Host side of the receive and transmit pins, with the host's pull-ups.
  Assumes the host releases its transmit drive while the device pulls down.
*/
module lin_host_model
(
  // Device pin drives.
  input  wire logic rxd_oe,
  input  wire logic txd_oe,
  input  wire logic txd_strong,
  input  wire logic host_txd,
  // Resolved line levels.
  output logic      rxd_line,
  output logic      txd_line
);
  timeunit 1ns;
  timeprecision 1ns;
  // A weak pull-down loses to the host pull-up, so a remote source reads high.
  assign rxd_line = !rxd_oe;
  assign txd_line = txd_oe ? !txd_strong : host_txd;
endmodule

/* tb_lin_wakeup_source_control.sv */
/*
  Self-checking bench for the wake-up and mode control.
  Assumes lin_wake_ctrl is the top module and the host model resolves the pins.
*/
module tb_lin_wakeup_source_control;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0, sys_rst = 1'b1, supply_ok = 1'b0, overtemp = 1'b0;
  logic prewake_threshold = 1'b0, dominant_level = 1'b0, overtemp_clear = 1'b0;
  logic en_pin = 1'b0, en_open = 1'b0, txd_open = 1'b0, wake_pin = 1'b1, host_txd = 1'b1;
  logic rxd_out, rxd_oe, txd_out, txd_oe, txd_strong, bus_drive_low;
  logic receiver_on, termination_on, regulator_inhibit_out, rxd_line, txd_line;
  int   err_count = 0, comparisons = 0, cycles = 0, i, n;
  int   seed = 32'h23f70a49;

  lin_wake_ctrl dut_u
  (
    .mclk(mclk), .sys_rst(sys_rst), .supply_ok(supply_ok),
    .prewake_threshold(prewake_threshold), .dominant_level(dominant_level),
    .overtemp(overtemp), .overtemp_clear(overtemp_clear), .en_pin(en_pin),
    .en_open(en_open), .txd_in(txd_line), .txd_open(txd_open), .wake_pin(wake_pin),
    .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd_out(txd_out), .txd_oe(txd_oe),
    .txd_strong(txd_strong), .bus_drive_low(bus_drive_low), .receiver_on(receiver_on),
    .termination_on(termination_on), .regulator_inhibit_out(regulator_inhibit_out)
  );

  lin_host_model host_u
  (
    .rxd_oe(rxd_oe), .txd_oe(txd_oe), .txd_strong(txd_strong),
    .host_txd(host_txd), .rxd_line(rxd_line), .txd_line(txd_line)
  );

  initial
  begin
    forever #50 mclk = ~mclk;
  end

  task test_done;
    $display("comparisons %0d errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task check_bit(input logic act, input logic exp);
    comparisons++;
    if (act !== exp)
    begin
      err_count++;
      $display("ERROR %0t: pin level %b, expected %b", $time, act, exp);
    end
  endtask

  task cyc(input int k);
    repeat (k) @(negedge mclk);
  endtask

  // Polls the inhibit output so the check does not hinge on exact latency.
  task wait_inh(input logic exp, input int bound);
    int k;
    k = 0;
    while (regulator_inhibit_out !== exp && k < bound)
    begin
      cyc(1);
      k++;
    end
    check_bit(regulator_inhibit_out, exp);
  endtask

  // Sleep is reached from fail-safe only through normal mode.
  task sleep_via_normal;
    host_txd = 1'b1;
    en_pin = 1'b1;
    cyc(5);
    en_pin = 1'b0;
    cyc(5);
    check_bit(regulator_inhibit_out, 1'b0);
  endtask

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      err_count++;
      test_done();
    end
  end

  initial
  begin
    cyc(4);
    sys_rst = 1'b0;
    supply_ok = 1'b1;
    wait_inh(1'b1, 10);
    en_pin = 1'b1;
    cyc(4);
    for (i = 0; i < 20; i++)
    begin
      host_txd = 1'($random(seed));
      dominant_level = 1'($random(seed));
      cyc(4);
      check_bit(bus_drive_low, !host_txd);
      check_bit(rxd_line, !dominant_level);
    end
    dominant_level = 1'b0;
    host_txd = 1'b1;
    txd_open = 1'b1;
    cyc(4);
    check_bit(bus_drive_low, 1'b1);
    txd_open = 1'b0;
    host_txd = 1'b0;
    overtemp = 1'b1;
    cyc(4);
    check_bit(bus_drive_low, 1'b0);
    overtemp = 1'b0;
    cyc(4);
    check_bit(bus_drive_low, 1'b0);
    overtemp_clear = 1'b1;
    cyc(4);
    check_bit(bus_drive_low, 1'b1);
    overtemp_clear = 1'b0;
    host_txd = 1'b1;
    cyc(4);
    en_open = 1'b1;
    cyc(5);
    check_bit(regulator_inhibit_out, 1'b0);
    en_pin = 1'b0;
    cyc(2);
    en_open = 1'b0;
    wake_pin = 1'b0;
    cyc(200);
    wake_pin = 1'b1;
    cyc(10);
    check_bit(regulator_inhibit_out, 1'b0);
    cyc(80);
    n = 380 + ($random(seed) & 63);
    wake_pin = 1'b0;
    wait_inh(1'b1, n);
    check_bit(termination_on, 1'b1);
    check_bit(rxd_line, 1'b0);
    check_bit(txd_line, 1'b0);
    check_bit(rxd_out, 1'b0);
    check_bit(txd_out, 1'b0);
    en_pin = 1'b1;
    cyc(4);
    check_bit(rxd_line, 1'b1);
    check_bit(txd_oe, 1'b0);
    en_pin = 1'b0;
    cyc(5);
    check_bit(regulator_inhibit_out, 1'b0);
    cyc(900);
    check_bit(regulator_inhibit_out, 1'b0);
    wake_pin = 1'b1;
    cyc(30);
    wake_pin = 1'b0;
    cyc(500);
    check_bit(regulator_inhibit_out, 1'b0);
    wake_pin = 1'b1;
    cyc(80);
    wake_pin = 1'b0;
    wait_inh(1'b1, 400);
    wake_pin = 1'b1;
    sleep_via_normal();
    check_bit(receiver_on, 1'b0);
    check_bit(termination_on, 1'b0);
    prewake_threshold = 1'b1;
    dominant_level = 1'b1;
    cyc(5);
    check_bit(receiver_on, 1'b1);
    check_bit(termination_on, 1'b1);
    cyc(400);
    dominant_level = 1'b0;
    prewake_threshold = 1'b0;
    cyc(10);
    check_bit(regulator_inhibit_out, 1'b0);
    prewake_threshold = 1'b1;
    dominant_level = 1'b1;
    cyc(940);
    check_bit(regulator_inhibit_out, 1'b0);
    dominant_level = 1'b0;
    prewake_threshold = 1'b0;
    wait_inh(1'b1, 20);
    check_bit(termination_on, 1'b1);
    check_bit(rxd_line, 1'b0);
    check_bit(txd_oe, 1'b1);
    check_bit(txd_line, 1'b1);
    en_pin = 1'b1;
    cyc(4);
    check_bit(rxd_line, 1'b1);
    check_bit(txd_oe, 1'b0);
    wake_pin = 1'b0;
    cyc(5);
    en_pin = 1'b0;
    cyc(400);
    check_bit(regulator_inhibit_out, 1'b0);
    test_done();
  end
endmodule
